// *** common/feiu_pkg.sv ***
// package for the fault event interrupt unit: offsets, fields, timing
package feiu_pkg;
    localparam logic [7:0] FEIU_ADDR_STATUS = 8'h02;
    localparam logic [7:0] FEIU_ADDR_ENABLE = 8'h03;
    localparam int FEIU_NUM_EVT = 5;
    localparam int FEIU_BIT_SHORT = 4;
    localparam int FEIU_BIT_HEAT = 3;
    localparam int FEIU_BIT_OVP = 2;
    localparam int FEIU_BIT_SENS_B = 1;
    localparam int FEIU_BIT_SENS_A = 0;
    localparam logic [7:0] FEIU_LIVE_MASK = 8'h1F;
    localparam logic [4:0] FEIU_STATUS_RST = 5'h00;
    localparam logic [4:0] FEIU_ENABLE_RST = 5'h00;
    localparam int FEIU_CLK_MHZ = 100;
    localparam int FEIU_GAP_US = 50;
    localparam int FEIU_GAP_CYC = FEIU_GAP_US * FEIU_CLK_MHZ;

    typedef struct packed {
        logic output_short;
        logic overheat;
        logic overvoltage;
        logic sensor_b;
        logic sensor_a;
    } feiu_evt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } feiu_req_t;

    typedef enum logic [2:0] {
        FEIU_IDLE = 3'b001,
        FEIU_ASSERT = 3'b010,
        FEIU_GAP = 3'b100
    } feiu_state_t;
endpackage : feiu_pkg

// *** core/feiu_top.sv ***
// event flags, enables and host interrupt line of the fault event unit
`timescale 1ns/100ps
module feiu_top
    import feiu_pkg::*;
#(
    parameter int GAP_CYCLES = FEIU_GAP_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // register access from the management port decoder
    input wire feiu_req_t i_req,
    output logic [7:0] o_rdata,
    // fault detectors and comparators, asynchronous
    input wire feiu_evt_t i_fault_raw,
    input wire logic i_sens_a_en,
    input wire logic i_sens_b_en,
    input wire logic i_pulse_mode,
    // host interrupt, active high
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for pins
    feiu_evt_t s1_reg, s2_reg, s3_reg;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= i_fault_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level faults set while present; comparators set on any edge
    feiu_evt_t hit;
    always_comb begin
        hit.output_short = s2_reg.output_short;
        hit.overheat = s2_reg.overheat;
        hit.overvoltage = s2_reg.overvoltage;
        hit.sensor_b = i_sens_b_en &
            (s2_reg.sensor_b ^ s3_reg.sensor_b);
        hit.sensor_a = i_sens_a_en &
            (s2_reg.sensor_a ^ s3_reg.sensor_a);
    end

    ////////////////////////////////////////////////////////////////////
    // status and enable registers
    logic [4:0] status_reg, status_next;
    logic [4:0] enable_reg, enable_next;
    logic [7:0] rdata_reg, rdata_next;
    logic wr_status, wr_enable, clr_any;
    logic [4:0] clr;

    always_comb begin
        wr_status = i_req.wr && (i_req.addr == FEIU_ADDR_STATUS);
        wr_enable = i_req.wr && (i_req.addr == FEIU_ADDR_ENABLE);
        // only ones in live bits clear; reserved bits dropped
        clr = wr_status ? i_req.wdata[4:0] : 5'h00;
        clr_any = |clr;
        // set wins over a clear in the same cycle; enable never gates set
        status_next = (status_reg & ~clr) | hit;
        // only the five live bits are stored; reserved writes fall away
        enable_next = wr_enable ?
            i_req.wdata[4:0] : enable_reg;
        rdata_next = rdata_reg;
        if (i_req.rd) begin
            unique case (i_req.addr)
                FEIU_ADDR_STATUS: rdata_next = {3'h0, status_reg};
                FEIU_ADDR_ENABLE: rdata_next = {3'h0, enable_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            status_reg <= FEIU_STATUS_RST;
            enable_reg <= FEIU_ENABLE_RST;
            rdata_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
            enable_reg <= enable_next;
            rdata_reg <= rdata_next;
        end
    end
    assign o_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // interrupt line with optional re-arm gap
    logic pend_now, pend_after;
    feiu_state_t st_reg, st_next;
    logic [$clog2(GAP_CYCLES+1)-1:0] gap_reg, gap_next;
    logic irq_reg, irq_next;

    always_comb begin
        pend_now = |(status_reg & enable_reg);
        pend_after = |(status_next & enable_next);
        st_next = st_reg;
        gap_next = gap_reg;
        unique case (st_reg)
            FEIU_IDLE: begin
                if (pend_after) begin
                    st_next = FEIU_ASSERT;
                end
            end
            FEIU_ASSERT: begin
                if (!pend_after) begin
                    st_next = FEIU_IDLE;
                end else if (clr_any && i_pulse_mode) begin
                    st_next = FEIU_GAP;
                    gap_next = '0;
                end
                // no pulse mode: stay high
            end
            FEIU_GAP: begin
                if (gap_reg == ($bits(gap_reg))'(GAP_CYCLES - 1)) begin
                    st_next = pend_after ? FEIU_ASSERT : FEIU_IDLE;
                end else begin
                    gap_next = gap_reg + 1'b1;
                end
            end
            default: st_next = FEIU_IDLE;
        endcase
        irq_next = (st_next == FEIU_ASSERT);
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= FEIU_IDLE;
            gap_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            gap_reg <= gap_next;
            irq_reg <= irq_next;
        end
    end
    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_flag_holds: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (status_reg[FEIU_BIT_SHORT] && !clr[FEIU_BIT_SHORT])
        |=> status_reg[FEIU_BIT_SHORT])
        else $error("short flag lost without clear");
    chk_clear_one: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (clr[FEIU_BIT_OVP] && !hit.overvoltage) |=> !status_reg[FEIU_BIT_OVP])
        else $error("overvoltage flag not cleared");
    chk_heat_set: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        hit.overheat |=> status_reg[FEIU_BIT_HEAT])
        else $error("overheat flag not set");
    chk_short_set: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s2_reg.output_short |=> status_reg[FEIU_BIT_SHORT])
        else $error("short flag not set");
    chk_sens_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (!i_sens_a_en && !status_reg[FEIU_BIT_SENS_A])
        |=> !status_reg[FEIU_BIT_SENS_A])
        else $error("disabled comparator set flag");
    chk_sens_b_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (!i_sens_b_en && !status_reg[FEIU_BIT_SENS_B])
        |=> !status_reg[FEIU_BIT_SENS_B])
        else $error("disabled second comparator set flag");
    chk_ovp_set: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        hit.overvoltage |=> status_reg[FEIU_BIT_OVP])
        else $error("overvoltage flag not set");
    chk_sens_a_edge: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_sens_a_en && $changed(s2_reg.sensor_a))
        |=> status_reg[FEIU_BIT_SENS_A])
        else $error("main comparator edge missed");
    chk_zero_keeps: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (wr_status && !i_req.wdata[FEIU_BIT_SENS_A] &&
         status_reg[FEIU_BIT_SENS_A]) |=> status_reg[FEIU_BIT_SENS_A])
        else $error("zero write cleared a flag");
    // outside the gap the line is exactly the registered pending state
    chk_short_irq: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (status_reg[FEIU_BIT_SHORT] && enable_reg[FEIU_BIT_SHORT] &&
         st_reg != FEIU_GAP) |-> o_irq)
        else $error("short event did not interrupt");
    chk_irq_match: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (st_reg != FEIU_GAP) |-> (o_irq == pend_now))
        else $error("irq differs from pending events");
    chk_en_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_enable |=> enable_reg == $past(i_req.wdata[4:0]))
        else $error("enable write lost");
    chk_en_stable: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !wr_enable |=> $stable(enable_reg))
        else $error("enable changed without write");
    chk_rd_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !i_req.rd |=> $stable(o_rdata))
        else $error("read data changed without read");
    chk_rd_status: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_req.rd && i_req.addr == FEIU_ADDR_STATUS)
        |=> o_rdata == {3'h0, $past(status_reg)})
        else $error("status read wrong");
    // the gap must not outlast its counter
    chk_gap_end: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (st_reg == FEIU_GAP && gap_reg == GAP_CYCLES - 1)
        |=> st_reg != FEIU_GAP)
        else $error("gap overran");
    chk_state_code: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $onehot(st_reg))
        else $error("interrupt state code illegal");
    chk_sens_b_edge: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_sens_b_en && $changed(s2_reg.sensor_b))
        |=> status_reg[FEIU_BIT_SENS_B])
        else $error("second comparator edge missed");
    chk_irq_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !pend_now |-> ##1 !o_irq || $past(pend_after))
        else $error("irq without pending event");
    chk_no_gap: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (o_irq && !i_pulse_mode && pend_after) |=> o_irq)
        else $error("irq gap outside pulse mode");
    chk_gap_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (st_reg == FEIU_ASSERT && st_next == FEIU_GAP) |=> !o_irq[*8])
        else $error("irq not low in gap");
    chk_rsvd_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_req.rd) |-> o_rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");
    chk_enable_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (status_reg[FEIU_BIT_OVP] && !enable_reg[FEIU_BIT_OVP] &&
         !clr[FEIU_BIT_OVP]) |=> status_reg[FEIU_BIT_OVP])
        else $error("masked flag lost");

    cov_gap: cover property (@(posedge i_mclk) st_reg == FEIU_GAP);
    cov_irq: cover property (@(posedge i_mclk) $rose(o_irq));
    cov_clear: cover property (@(posedge i_mclk) clr_any && o_irq);
    cov_set_clr: cover property (@(posedge i_mclk) |(clr & hit));
    cov_masked: cover property (@(posedge i_mclk) |(status_reg & ~enable_reg));
endmodule : feiu_top

// *** tb/feiu_host_model.sv ***
// host model: register requests over the management port
`timescale 1ns/100ps
module feiu_host_model
    import feiu_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // register access
    output feiu_req_t o_req,
    input wire logic [7:0] i_rdata
);
    initial o_req = '0;
    // enter and leave at a rising edge; one idle edge avoids double drive
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        o_req <= '0;
        @(posedge i_mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_mclk);
        o_req <= '0;
        @(posedge i_mclk);
        d = i_rdata;
    endtask : rd
endmodule : feiu_host_model

// *** tb/feiu_top_bench.sv ***
// self-checking bench for the fault event interrupt unit
`timescale 1ns/100ps
module feiu_top_bench;
    import feiu_pkg::*;
    localparam int GAP = 20;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    feiu_req_t req;
    logic [7:0] rdata;
    logic [4:0] raw = 5'h00;
    logic sa_en = 1'b1;
    logic sb_en = 1'b1;
    logic pulse = 1'b0;
    logic irq;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] d;
    logic [7:0] en;
    always #5 i_mclk = ~i_mclk;
    feiu_top #(.GAP_CYCLES(GAP)) dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_req(req), .o_rdata(rdata), .i_fault_raw(feiu_evt_t'(raw)),
        .i_sens_a_en(sa_en), .i_sens_b_en(sb_en), .i_pulse_mode(pulse),
        .o_irq(irq));
    feiu_host_model host (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] bit_of(input int i);
        return 8'h01 << i;
    endfunction : bit_of
    // sampled at the falling edge, clear of the register update
    task automatic irq_is(input logic exp);
        @(negedge i_mclk);
        check({7'h00, irq}, {7'h00, exp});
        @(posedge i_mclk);
    endtask : irq_is
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(86221));
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        host.rd(FEIU_ADDR_STATUS, d);
        check(d, 8'h00);
        host.wr(FEIU_ADDR_ENABLE, 8'hFF);
        host.rd(FEIU_ADDR_ENABLE, d);
        check(d, 8'h1F);
        host.rd(8'h05, d);
        check(d, 8'h00);
        $display("test regs done");
        for (int i = 0; i < FEIU_NUM_EVT; i++) begin
            en = 8'($urandom);
            host.wr(FEIU_ADDR_ENABLE, en);
            host.rd(FEIU_ADDR_ENABLE, d);
            check(d, en & 8'h1F);
            raw <= raw ^ 5'(bit_of(i));
            repeat (5) @(posedge i_mclk);
            // level faults must fall again before a clear can stick
            if (i >= 2) raw <= raw ^ 5'(bit_of(i));
            repeat (5) @(posedge i_mclk);
            host.rd(FEIU_ADDR_STATUS, d);
            check(d, bit_of(i));
            irq_is(en[i]);
            host.wr(FEIU_ADDR_STATUS, ~bit_of(i));
            host.rd(FEIU_ADDR_STATUS, d);
            check(d, bit_of(i));
            host.wr(FEIU_ADDR_STATUS, bit_of(i));
            host.rd(FEIU_ADDR_STATUS, d);
            check(d, 8'h00);
            irq_is(1'b0);
        end
        sa_en <= 1'b0;
        raw <= raw ^ 5'h01;
        repeat (6) @(posedge i_mclk);
        host.rd(FEIU_ADDR_STATUS, d);
        check(d, 8'h00);
        $display("test flags done");
        host.wr(FEIU_ADDR_ENABLE, 8'h1F);
        pulse <= 1'b1;
        raw <= raw | 5'h0C;
        repeat (4) @(posedge i_mclk);
        raw <= raw & 5'h13;
        repeat (5) @(posedge i_mclk);
        host.wr(FEIU_ADDR_STATUS, 8'h04);
        irq_is(1'b0);
        repeat (GAP) @(posedge i_mclk);
        irq_is(1'b1);
        pulse <= 1'b0;
        raw <= raw | 5'h04;
        repeat (4) @(posedge i_mclk);
        raw <= raw & 5'h13;
        repeat (5) @(posedge i_mclk);
        host.wr(FEIU_ADDR_STATUS, 8'h04);
        repeat (3) irq_is(1'b1);
        host.wr(FEIU_ADDR_STATUS, 8'h1F);
        irq_is(1'b0);
        $display("test pulse done");
        give_verdict();
    end
endmodule : feiu_top_bench
